// ### sic_pkg.sv
// Register map, field positions and reset values of the interrupt control block
package sic_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [15:0] SIC_OFF_SUBSYS     = 16'h8504;
	localparam logic [15:0] SIC_OFF_ADV_FUNC   = 16'h850c;
	localparam logic [15:0] SIC_OFF_LEGACY     = 16'h8510;
	localparam int          SIC_ADDR_W         = 16;

	// ==========================================================
	// Status word fields
	localparam int SIC_EV_VSYNC      = 0;
	localparam int SIC_EV_ENG_DONE   = 1;
	localparam int SIC_EV_CMD_OVF    = 2;
	localparam int SIC_EV_CMD_EMPTY  = 3;
	localparam int SIC_EV_HOST_DMA   = 4;
	localparam int SIC_EV_CMD_DMA    = 5;
	localparam int SIC_EV_RFIFO_EMP  = 6;
	localparam int SIC_EV_PERIPH     = 7;
	localparam int SIC_NUM_EV        = 8;
	localparam int SIC_NUM_CLR       = 7;
	localparam int SIC_ST_FREE_LSB   = 8;
	localparam int SIC_ST_FREE_W     = 5;
	localparam int SIC_ST_IDLE       = 13;

	// ==========================================================
	// Control word fields
	localparam int SIC_CT_HDMA_EN    = 7;
	localparam int SIC_CT_VSYNC_EN   = 8;
	localparam int SIC_CT_DONE_EN    = 9;
	localparam int SIC_CT_OVF_EN     = 10;
	localparam int SIC_CT_EMP_EN     = 11;
	localparam int SIC_CT_CDMA_EN    = 12;
	localparam int SIC_CT_RFIFO_EN   = 13;
	localparam int SIC_CT_RST_LSB    = 14;

	// Engine reset codes
	localparam logic [1:0] SIC_RST_KEEP   = 2'h0;
	localparam logic [1:0] SIC_RST_ENABLE = 2'h1;
	localparam logic [1:0] SIC_RST_HOLD   = 2'h2;

	// ==========================================================
	// Advanced function control fields
	localparam int SIC_AF_ENH        = 0;
	localparam int SIC_AF_DMA_RST    = 1;
	localparam int SIC_AF_LINEAR     = 4;
	localparam int SIC_AF_CMD_LSB    = 6;
	localparam int SIC_AF_CMD_W      = 4;

	// ==========================================================
	// Legacy control register fields
	localparam int SIC_LG_GLOBAL_EN  = 0;
	localparam int SIC_LG_ALT_RST    = 1;
	localparam int SIC_LG_ENH        = 2;
	localparam int SIC_LG_LINEAR     = 3;
	localparam int SIC_LG_PERIPH_EN  = 4;
	localparam int SIC_LG_PERIPH_CLR = 8;

	// ==========================================================
	// Reset values
	localparam logic [31:0] SIC_WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0]  SIC_EV_ZERO   = 8'h00;

	// AHB encodings
	localparam logic [1:0] SIC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] SIC_HSIZE_WORD    = 3'h2;

	typedef enum logic [1:0] {
		SIC_ENG_RUN   = 2'b01,
		SIC_ENG_RESET = 2'b10
	} sic_eng_state_t;

endpackage : sic_pkg

// ### sic_subsystem_interrupt_control.sv
// Subsystem interrupt status, clear, enable, engine reset and function control
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sic_subsystem_interrupt_control #(
	parameter int RENDER_FIFO_DEPTH = 16,
	parameter int CMD_FIFO_DEPTH    = 8
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// Event sources
	input  wire logic        i_vsync,
	input  wire logic        i_engine_busy,
	input  wire logic        i_cmd_fifo_overflow,
	input  wire logic        i_cmd_fifo_empty,
	input  wire logic        i_host_dma_done,
	input  wire logic        i_cmd_dma_done,
	input  wire logic        i_render_fifo_empty,
	input  wire logic        i_peripheral_bus_irq,
	input  wire logic [4:0]  i_render_fifo_free_count,
	input  wire logic [3:0]  i_cmd_fifo_free_count,
	// Controls
	output logic             o_irq,
	output logic             o_engine_reset,
	output logic             o_enhanced_mode_select,
	output logic             o_linear_addressing_enable,
	output logic             o_read_dma_pointer_reset
);

	// ==========================================================
	// Parameter check
	// Depths beyond the free-count field widths cannot be reported
	if (RENDER_FIFO_DEPTH < 1 || RENDER_FIFO_DEPTH > 31) begin : g_bad_render
		$error("render FIFO depth must fit the five-bit free count");
	end
	if (CMD_FIFO_DEPTH < 1 || CMD_FIFO_DEPTH > 15) begin : g_bad_cmd
		$error("command FIFO depth must fit the four-bit free count");
	end

	// ==========================================================
	// Address decode helper
	function automatic logic reg_hit(
		input logic [31:0] addr,
		input logic [15:0] offset
	);
		reg_hit = (addr[sic_pkg::SIC_ADDR_W-1:0] == offset);
	endfunction : reg_hit

	// Rising edge of a level against its value one clock earlier
	function automatic logic rise_of(
		input logic now_level,
		input logic last_level
	);
		rise_of = now_level & ~last_level;
	endfunction : rise_of

	// ==========================================================
	// Declarations
	logic                           vsync_meta_q;
	logic                           vsync_sync_q;
	logic                           vsync_prev_q;
	logic                           busy_prev_q;
	logic                           cmd_empty_prev_q;
	logic                           rfifo_empty_prev_q;
	logic [sic_pkg::SIC_NUM_EV-1:0] event_set;
	logic [sic_pkg::SIC_NUM_EV-1:0] event_clr;
	logic [sic_pkg::SIC_NUM_EV-1:0] status_q;
	logic [sic_pkg::SIC_NUM_EV-1:0] status_d;
	logic [sic_pkg::SIC_NUM_EV-1:0] enable_q;
	logic                           global_en_q;
	logic                           alt_reset_q;
	logic                           legacy_enh_q;
	logic                           legacy_linear_q;
	logic                           enh_q;
	logic                           dma_rst_q;
	logic                           linear_q;
	sic_pkg::sic_eng_state_t        eng_state_q;
	logic                           addr_ok;
	logic                           wr_pend_q;
	logic [31:0]                    wr_addr_q;
	logic                           wr_ctrl;
	logic                           wr_adv;
	logic                           wr_legacy;
	logic [31:0]                    status_word;
	logic [31:0]                    adv_word;
	logic [31:0]                    legacy_word;
	logic [31:0]                    rdata_d;
	logic [1:0]                     reset_code;
	logic [sic_pkg::SIC_ST_FREE_W-1:0] render_free;
	logic [sic_pkg::SIC_AF_CMD_W-1:0]  cmd_free;

	localparam logic [sic_pkg::SIC_ST_FREE_W-1:0] RENDER_FREE_MAX =
		RENDER_FIFO_DEPTH[sic_pkg::SIC_ST_FREE_W-1:0];
	localparam logic [sic_pkg::SIC_AF_CMD_W-1:0]  CMD_FREE_MAX    =
		CMD_FIFO_DEPTH[sic_pkg::SIC_AF_CMD_W-1:0];

	// ==========================================================
	// Vertical sync pin synchroniser and edge history
	// Only the second stage is read; the third keeps the edge history
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			vsync_meta_q <= 1'b0;
			vsync_sync_q <= 1'b0;
			vsync_prev_q <= 1'b0;
		end else begin
			vsync_meta_q <= i_vsync;
			vsync_sync_q <= vsync_meta_q;
			vsync_prev_q <= vsync_sync_q;
		end
	end

	// Empty inputs rest high, so their history starts high: a FIFO that is
	// already empty when reset ends is not an event
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			busy_prev_q        <= 1'b0;
			cmd_empty_prev_q   <= 1'b1;
			rfifo_empty_prev_q <= 1'b1;
		end else begin
			busy_prev_q        <= i_engine_busy;
			cmd_empty_prev_q   <= i_cmd_fifo_empty;
			rfifo_empty_prev_q <= i_render_fifo_empty;
		end
	end

	// ==========================================================
	// Event detection
	always_comb begin
		event_set = sic_pkg::SIC_EV_ZERO;
		event_set[sic_pkg::SIC_EV_VSYNC]     = rise_of(vsync_sync_q, vsync_prev_q);
		event_set[sic_pkg::SIC_EV_ENG_DONE]  = busy_prev_q & ~i_engine_busy;
		event_set[sic_pkg::SIC_EV_CMD_OVF]   = i_cmd_fifo_overflow;
		event_set[sic_pkg::SIC_EV_CMD_EMPTY] = rise_of(i_cmd_fifo_empty, cmd_empty_prev_q);
		event_set[sic_pkg::SIC_EV_HOST_DMA]  = i_host_dma_done;
		event_set[sic_pkg::SIC_EV_CMD_DMA]   = i_cmd_dma_done;
		event_set[sic_pkg::SIC_EV_RFIFO_EMP] = rise_of(i_render_fifo_empty, rfifo_empty_prev_q);
		event_set[sic_pkg::SIC_EV_PERIPH]    = i_peripheral_bus_irq;
	end

	// ==========================================================
	// Free counts, held to the FIFO depths
	// A source that glitches past its depth must not report slots that do
	// not exist, or software would overrun the FIFO.
	always_comb begin
		render_free = i_render_fifo_free_count;
		if (i_render_fifo_free_count > RENDER_FREE_MAX) begin
			render_free = RENDER_FREE_MAX;
		end
		cmd_free = i_cmd_fifo_free_count;
		if (i_cmd_fifo_free_count > CMD_FREE_MAX) begin
			cmd_free = CMD_FREE_MAX;
		end
	end

	// ==========================================================
	// AHB-Lite access decode
	assign addr_ok = i_hsel & i_hready & (i_htrans == sic_pkg::SIC_HTRANS_NONSEQ)
		& (i_hsize == sic_pkg::SIC_HSIZE_WORD);

	// Address is held over for the data phase, where hwdata is valid

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= sic_pkg::SIC_WORD_ZERO;
		end else begin
			wr_pend_q <= addr_ok & i_hwrite;
			wr_addr_q <= i_haddr;
		end
	end

	assign wr_ctrl   = wr_pend_q & reg_hit(wr_addr_q, sic_pkg::SIC_OFF_SUBSYS);
	assign wr_adv    = wr_pend_q & reg_hit(wr_addr_q, sic_pkg::SIC_OFF_ADV_FUNC);
	assign wr_legacy = wr_pend_q & reg_hit(wr_addr_q, sic_pkg::SIC_OFF_LEGACY);

	// ==========================================================
	// Sticky status flags
	always_comb begin
		event_clr = sic_pkg::SIC_EV_ZERO;
		if (wr_ctrl) begin
			event_clr[sic_pkg::SIC_NUM_CLR-1:0] = i_hwdata[sic_pkg::SIC_NUM_CLR-1:0];
		end
		if (wr_legacy) begin
			event_clr[sic_pkg::SIC_EV_PERIPH] = i_hwdata[sic_pkg::SIC_LG_PERIPH_CLR];
		end
		// An event in the cycle of its clear wins, so no event is lost
		status_d = (status_q & ~event_clr) | event_set;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			status_q <= sic_pkg::SIC_EV_ZERO;
		end else begin
			status_q <= status_d;
		end
	end

	// ==========================================================
	// Interrupt enables from the control word; the peripheral enable from the legacy register
	// The control word is write-only: enables do not read back there
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			enable_q <= sic_pkg::SIC_EV_ZERO;
		end else begin
			if (wr_ctrl) begin
				enable_q[sic_pkg::SIC_EV_HOST_DMA]  <= i_hwdata[sic_pkg::SIC_CT_HDMA_EN];
				enable_q[sic_pkg::SIC_EV_VSYNC]     <= i_hwdata[sic_pkg::SIC_CT_VSYNC_EN];
				enable_q[sic_pkg::SIC_EV_ENG_DONE]  <= i_hwdata[sic_pkg::SIC_CT_DONE_EN];
				enable_q[sic_pkg::SIC_EV_CMD_OVF]   <= i_hwdata[sic_pkg::SIC_CT_OVF_EN];
				enable_q[sic_pkg::SIC_EV_CMD_EMPTY] <= i_hwdata[sic_pkg::SIC_CT_EMP_EN];
				enable_q[sic_pkg::SIC_EV_CMD_DMA]   <= i_hwdata[sic_pkg::SIC_CT_CDMA_EN];
				enable_q[sic_pkg::SIC_EV_RFIFO_EMP] <= i_hwdata[sic_pkg::SIC_CT_RFIFO_EN];
			end
			if (wr_legacy) begin
				enable_q[sic_pkg::SIC_EV_PERIPH] <= i_hwdata[sic_pkg::SIC_LG_PERIPH_EN];
			end
		end
	end

	// ==========================================================
	// Legacy control bits
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			global_en_q     <= 1'b0;
			alt_reset_q     <= 1'b0;
			legacy_enh_q    <= 1'b0;
			legacy_linear_q <= 1'b0;
		end else if (wr_legacy) begin
			global_en_q     <= i_hwdata[sic_pkg::SIC_LG_GLOBAL_EN];
			alt_reset_q     <= i_hwdata[sic_pkg::SIC_LG_ALT_RST];
			legacy_enh_q    <= i_hwdata[sic_pkg::SIC_LG_ENH];
			legacy_linear_q <= i_hwdata[sic_pkg::SIC_LG_LINEAR];
		end
	end

	// ==========================================================
	// Advanced function control
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			enh_q     <= 1'b0;
			dma_rst_q <= 1'b0;
			linear_q  <= 1'b0;
		end else if (wr_adv) begin
			enh_q     <= i_hwdata[sic_pkg::SIC_AF_ENH];
			dma_rst_q <= i_hwdata[sic_pkg::SIC_AF_DMA_RST];
			linear_q  <= i_hwdata[sic_pkg::SIC_AF_LINEAR];
		end
	end

	// ==========================================================
	// Engine software reset
	// Codes 00 and 11 leave the state alone; the alternate reset is a level
	// ORed in at the output, so clearing it releases the engine unless code 10 still holds it
	assign reset_code = i_hwdata[sic_pkg::SIC_CT_RST_LSB +: 2];

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			eng_state_q <= sic_pkg::SIC_ENG_RUN;
		end else begin
			case (eng_state_q)
				sic_pkg::SIC_ENG_RUN: begin
					if (wr_ctrl && reset_code == sic_pkg::SIC_RST_HOLD) begin
						eng_state_q <= sic_pkg::SIC_ENG_RESET;
					end
				end
				sic_pkg::SIC_ENG_RESET: begin
					if (wr_ctrl && reset_code == sic_pkg::SIC_RST_ENABLE) begin
						eng_state_q <= sic_pkg::SIC_ENG_RUN;
					end
				end
				default: begin
					eng_state_q <= sic_pkg::SIC_ENG_RUN;
				end
			endcase
		end
	end

	// ==========================================================
	// Read data, captured in the address phase
	// Zero wait states: the word stands for the data phase only, zero otherwise
	always_comb begin
		status_word = sic_pkg::SIC_WORD_ZERO;
		status_word[sic_pkg::SIC_NUM_EV-1:0] = status_q;
		status_word[sic_pkg::SIC_ST_FREE_LSB +: sic_pkg::SIC_ST_FREE_W] =
			render_free;
		status_word[sic_pkg::SIC_ST_IDLE] = ~i_engine_busy;
		adv_word = sic_pkg::SIC_WORD_ZERO;
		adv_word[sic_pkg::SIC_AF_ENH]     = enh_q;
		adv_word[sic_pkg::SIC_AF_DMA_RST] = dma_rst_q;
		adv_word[sic_pkg::SIC_AF_LINEAR]  = linear_q;
		adv_word[sic_pkg::SIC_AF_CMD_LSB +: sic_pkg::SIC_AF_CMD_W] =
			cmd_free;
		legacy_word = sic_pkg::SIC_WORD_ZERO;
		legacy_word[sic_pkg::SIC_LG_GLOBAL_EN] = global_en_q;
		legacy_word[sic_pkg::SIC_LG_ALT_RST]   = alt_reset_q;
		legacy_word[sic_pkg::SIC_LG_ENH]       = legacy_enh_q;
		legacy_word[sic_pkg::SIC_LG_LINEAR]    = legacy_linear_q;
		legacy_word[sic_pkg::SIC_LG_PERIPH_EN] = enable_q[sic_pkg::SIC_EV_PERIPH];
		rdata_d = sic_pkg::SIC_WORD_ZERO;
		if (addr_ok && !i_hwrite) begin
			if (reg_hit(i_haddr, sic_pkg::SIC_OFF_SUBSYS)) begin
				rdata_d = status_word;
			end else if (reg_hit(i_haddr, sic_pkg::SIC_OFF_ADV_FUNC)) begin
				rdata_d = adv_word;
			end else if (reg_hit(i_haddr, sic_pkg::SIC_OFF_LEGACY)) begin
				rdata_d = legacy_word;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_hrdata    <= sic_pkg::SIC_WORD_ZERO;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			o_hrdata    <= rdata_d;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

	// ==========================================================
	// Registered outputs
	// The interrupt follows its flag by one cycle so that it leaves a flip-flop
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= global_en_q & (|(status_q & enable_q));
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_engine_reset             <= 1'b0;
			o_enhanced_mode_select     <= 1'b0;
			o_linear_addressing_enable <= 1'b0;
			o_read_dma_pointer_reset   <= 1'b0;
		end else begin
			o_engine_reset <= (eng_state_q == sic_pkg::SIC_ENG_RESET)
				| alt_reset_q;
			o_enhanced_mode_select     <= enh_q | legacy_enh_q;
			o_linear_addressing_enable <= linear_q | legacy_linear_q;
			o_read_dma_pointer_reset   <= dma_rst_q;
		end
	end

endmodule : sic_subsystem_interrupt_control

// ### sic_subsystem_interrupt_control_properties.sv
// Port-level assertions of the interrupt control block
`timescale 1ns/1ps
module sic_subsystem_interrupt_control_properties (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [2:0]  i_hsize,
	input wire logic        i_hready,
	input wire logic [31:0] i_hwdata,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        i_engine_busy,
	input wire logic [4:0]  i_render_fifo_free_count,
	input wire logic [3:0]  i_cmd_fifo_free_count,
	input wire logic        o_irq,
	input wire logic        o_engine_reset,
	input wire logic        o_enhanced_mode_select,
	input wire logic        o_linear_addressing_enable,
	input wire logic        o_read_dma_pointer_reset
);
	// ==========================================================
	// Transfer decode
	logic        tk;
	logic        rd_tk;
	logic [15:0] a;
	assign tk = i_hsel && i_hready && i_htrans == sic_pkg::SIC_HTRANS_NONSEQ
		&& i_hsize == sic_pkg::SIC_HSIZE_WORD;
	assign rd_tk = tk && !i_hwrite;
	assign a  = i_haddr[15:0];

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence wr_adv;
		tk && i_hwrite && a == sic_pkg::SIC_OFF_ADV_FUNC;
	endsequence
	sequence wr_leg;
		tk && i_hwrite && a == sic_pkg::SIC_OFF_LEGACY;
	endsequence

	// ==========================================================
	// Assertions
	a_bus_always_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready and okay");
	a_idle_read_zero: assert property (!$past(rd_tk) |-> o_hrdata == 32'h0000_0000)
		else $error("read data outside a read data phase");
	a_status_live_fields: assert property (tk && !i_hwrite && a == sic_pkg::SIC_OFF_SUBSYS |=>
		o_hrdata[31:8] == {18'h0_0000, !$past(i_engine_busy), $past(i_render_fifo_free_count)})
		else $error("status free count or idle bit wrong");
	a_cmd_free_field: assert property (tk && !i_hwrite && a == sic_pkg::SIC_OFF_ADV_FUNC |=>
		o_hrdata[9:6] == $past(i_cmd_fifo_free_count))
		else $error("command free count wrong");
	a_dma_reset_set: assert property ((wr_adv ##1 i_hwdata[1]) |-> ##[1:2] o_read_dma_pointer_reset)
		else $error("read pointer reset not driven");
	a_dma_reset_drop: assert property ((wr_adv ##1 !i_hwdata[1]) |-> ##[1:2] !o_read_dma_pointer_reset)
		else $error("read pointer reset not released");
	a_enhanced_follows: assert property ((wr_adv ##1 i_hwdata[0]) |-> ##[1:2] o_enhanced_mode_select)
		else $error("enhanced mode not selected");
	a_linear_follows: assert property ((wr_adv ##1 i_hwdata[4]) |-> ##[1:2] o_linear_addressing_enable)
		else $error("linear addressing not enabled");
	a_alt_reset_force: assert property ((wr_leg ##1 i_hwdata[1]) |-> ##[1:2] o_engine_reset)
		else $error("alternate reset did not hold engine");
	a_hold_code_reset: assert property ((tk && i_hwrite && a == sic_pkg::SIC_OFF_SUBSYS
		##1 i_hwdata[15:14] == sic_pkg::SIC_RST_HOLD) |-> ##[1:2] o_engine_reset)
		else $error("reset code did not hold engine");
	a_global_gate: assert property ((wr_leg ##1 !i_hwdata[0]) |-> ##2 !o_irq)
		else $error("interrupt without global enable");

	c_irq_seen: cover property (o_irq);
	c_engine_held: cover property (o_engine_reset);
	c_control_write: cover property (tk && i_hwrite && a == sic_pkg::SIC_OFF_SUBSYS);
endmodule : sic_subsystem_interrupt_control_properties

bind sic_subsystem_interrupt_control sic_subsystem_interrupt_control_properties u_props (.*);

// ### sic_subsystem_interrupt_control_tb_top.sv
// Self-checking testbench of the interrupt control block
`timescale 1ns/1ps
module sic_subsystem_interrupt_control_tb_top;
	localparam logic [31:0] ST = 32'h0000_8504;
	localparam logic [31:0] AF = 32'h0000_850c;
	localparam logic [31:0] LG = 32'h0000_8510;
	localparam logic [31:0] Z  = 32'h0000_0000;
	logic        i_ref_clk, i_rst_n, i_hsel, i_hwrite, i_vsync, i_engine_busy;
	logic        i_cmd_fifo_overflow, i_cmd_fifo_empty, i_host_dma_done, i_cmd_dma_done;
	logic        i_render_fifo_empty, i_peripheral_bus_irq, o_hreadyout, o_hresp, o_irq;
	logic        o_engine_reset, o_enhanced_mode_select, o_linear_addressing_enable;
	logic        o_read_dma_pointer_reset;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
	logic [1:0]  i_htrans;
	logic [2:0]  i_hsize;
	logic [4:0]  i_render_fifo_free_count;
	logic [3:0]  i_cmd_fifo_free_count;
	wire logic   i_hready;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cycles    = 0;

	assign i_hready = o_hreadyout;
	sic_subsystem_interrupt_control dut (.*);

	always #50 i_ref_clk = ~i_ref_clk;

	// ==========================================================
	// Hang guard
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			complete_run();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic complete_run;
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic flag(input logic seen, input logic exp);
		check(32'(seen), 32'(exp));
	endtask : flag

	function automatic logic [31:0] outs();
		return {29'h0000_0000, o_linear_addressing_enable, o_read_dma_pointer_reset,
			o_enhanced_mode_select};
	endfunction : outs

	// Single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		@(posedge i_ref_clk);
		i_hsel   <= 1'b1;
		i_htrans <= sic_pkg::SIC_HTRANS_NONSEQ;
		i_haddr  <= addr;
		i_hwrite <= wr;
		@(posedge i_ref_clk);
		while (i_hready !== 1'b1) @(posedge i_ref_clk);
		i_hsel   <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wr ? data : Z;
		@(posedge i_ref_clk);
		while (i_hready !== 1'b1) @(posedge i_ref_clk);
		rd = o_hrdata;
	endtask : bus

	task automatic settle;
		repeat (4) @(posedge i_ref_clk);
		#1;
	endtask : settle

	// ==========================================================
	// Scenarios
	task automatic t_read_map;
		bus(1'b0, ST, Z);
		check(rd, 32'h0000_1000);
		flag(o_hreadyout, 1'b1);
		flag(o_hresp, 1'b0);
		i_render_fifo_free_count <= 5'h00;
		i_cmd_fifo_free_count    <= 4'h8;
		bus(1'b0, AF, Z);
		check(rd, 32'h0000_0200);
		bus(1'b0, 32'h0000_8600, Z);
		check(rd, Z);
	endtask : t_read_map

	task automatic t_events;
		bus(1'b1, ST, 32'h0000_007f);
		i_vsync              <= 1'b1;
		i_engine_busy        <= 1'b0;
		i_cmd_fifo_overflow  <= 1'b1;
		i_cmd_fifo_empty     <= 1'b1;
		i_host_dma_done      <= 1'b1;
		i_cmd_dma_done       <= 1'b1;
		i_render_fifo_empty  <= 1'b1;
		i_peripheral_bus_irq <= 1'b1;
		@(posedge i_ref_clk);
		i_cmd_fifo_overflow  <= 1'b0;
		i_host_dma_done      <= 1'b0;
		i_cmd_dma_done       <= 1'b0;
		i_peripheral_bus_irq <= 1'b0;
		settle;
		bus(1'b1, ST, Z);
		bus(1'b0, ST, Z);
		check(rd, 32'h0000_20ff);
		bus(1'b1, ST, 32'h0000_007f);
		bus(1'b0, ST, Z);
		check(rd, 32'h0000_2080);
		bus(1'b1, LG, 32'h0000_0100);
		bus(1'b0, ST, Z);
		check(rd, 32'h0000_2000);
	endtask : t_events

	task automatic t_irq;
		bus(1'b1, ST, 32'h0000_0400);
		i_cmd_fifo_overflow <= 1'b1;
		@(posedge i_ref_clk);
		i_cmd_fifo_overflow <= 1'b0;
		settle;
		flag(o_irq, 1'b0);
		bus(1'b1, LG, 32'h0000_0001);
		settle;
		flag(o_irq, 1'b1);
		bus(1'b1, ST, Z);
		settle;
		flag(o_irq, 1'b0);
		bus(1'b1, ST, 32'h0000_0400);
		settle;
		flag(o_irq, 1'b1);
		bus(1'b1, ST, 32'h0000_0404);
		settle;
		flag(o_irq, 1'b0);
		bus(1'b1, LG, Z);
	endtask : t_irq

	task automatic t_engine;
		logic [1:0] code [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
		logic       want [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, ST, {16'h0000, code[k], 14'h0000});
			settle;
			flag(o_engine_reset, want[k]);
		end
		bus(1'b1, LG, 32'h0000_0002);
		settle;
		flag(o_engine_reset, 1'b1);
		bus(1'b1, LG, Z);
		settle;
		flag(o_engine_reset, 1'b0);
	endtask : t_engine

	task automatic t_adv;
		bus(1'b1, AF, 32'h0000_0013);
		settle;
		check(outs(), 32'h0000_0007);
		bus(1'b0, AF, Z);
		check(rd, 32'h0000_0213);
		bus(1'b1, AF, Z);
		settle;
		check(outs(), Z);
		bus(1'b1, LG, 32'h0000_000c);
		settle;
		check(outs(), 32'h0000_0005);
		bus(1'b1, LG, Z);
	endtask : t_adv

	// ==========================================================
	// Main sequence
	initial begin
		i_ref_clk                = 1'b0;
		i_rst_n                  = 1'b0;
		i_hsel                   = 1'b0;
		i_hwrite                 = 1'b0;
		i_haddr                  = Z;
		i_hwdata                 = Z;
		i_htrans                 = 2'h0;
		i_hsize                  = sic_pkg::SIC_HSIZE_WORD;
		i_vsync                  = 1'b0;
		i_engine_busy            = 1'b1;
		i_cmd_fifo_overflow      = 1'b0;
		i_cmd_fifo_empty         = 1'b0;
		i_host_dma_done          = 1'b0;
		i_cmd_dma_done           = 1'b0;
		i_render_fifo_empty      = 1'b0;
		i_peripheral_bus_irq     = 1'b0;
		i_render_fifo_free_count = 5'h10;
		i_cmd_fifo_free_count    = 4'h0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		t_read_map();
		t_events();
		t_irq();
		t_engine();
		t_adv();
		complete_run();
	end
endmodule : sic_subsystem_interrupt_control_tb_top
